// *** pkg/cis_pkg.sv ***
// constants for the charger input supervisor
package cis_pkg;

    // ********************************************************
    // bus geometry and register offsets
    // ********************************************************
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int MW = 16;

    localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
    localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [AW-1:0] OFF_STATUS   = 8'h0c;
    localparam logic [AW-1:0] OFF_ILIM     = 8'h10;
    localparam logic [AW-1:0] OFF_CHG      = 8'h14;
    localparam logic [AW-1:0] OFF_RAIL_REF = 8'h18;

    // ********************************************************
    // field positions and reset values
    // ********************************************************
    localparam int CTRL_OVP_LSB = 0;
    localparam int CTRL_CON_EN  = 2;
    localparam int CTRL_DIS_EN  = 3;
    localparam int CTRL_W       = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

    localparam int IRQ_CON = 0;
    localparam int IRQ_DIS = 1;
    localparam int IRQ_IN  = 2;
    localparam int IRQ_W   = 3;
    localparam logic [IRQ_W-1:0] IRQ_STAT_RST = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h7;

    localparam int ST_VALID   = 0;
    localparam int ST_ADAPTER = 1;
    localparam int ST_CHG_EN  = 2;
    localparam int ST_OVP     = 3;
    localparam int ST_UVLO    = 4;
    localparam int ST_DCR     = 5;
    localparam int ST_PATH_IN = 6;
    localparam int ST_PATH_BT = 7;
    localparam int ST_SHIFT   = 8;

    localparam logic [MW-1:0] RAIL_REF_RST = 16'h1130;

    // ********************************************************
    // voltages in millivolts
    // ********************************************************
    localparam logic [MW-1:0] OVP_TH_00   = 16'h19c8;
    localparam logic [MW-1:0] OVP_TH_01   = 16'h1b58;
    localparam logic [MW-1:0] OVP_TH_10   = 16'h1d4c;
    localparam logic [MW-1:0] OVP_TH_11   = 16'h1f40;
    localparam logic [MW-1:0] OVP_RESUME  = 16'h1770;
    localparam logic [MW-1:0] UVLO_TH     = 16'h0dac;
    localparam logic [MW-1:0] UVLO_HYST   = 16'h01f4;
    localparam logic [MW-1:0] RAIL_DROOP  = 16'h00c8;

    // ********************************************************
    // currents in milliamps and current divisors
    // ********************************************************
    localparam logic [MW-1:0] ILIM_USB_LO = 16'h0064;
    localparam logic [MW-1:0] ILIM_USB_HI = 16'h01c2;
    localparam logic [MW-1:0] ILIM_AC     = 16'h07d0;
    localparam logic [MW-1:0] CHG_USB_LO  = 16'h005a;
    localparam logic [MW-1:0] CHG_USB_HI  = 16'h01c2;
    localparam logic [MW-1:0] PRE_USB     = 16'h002d;
    localparam logic [MW-1:0] AC_LOW_DIV  = 16'h0005;
    localparam logic [MW-1:0] PRE_AC_DIV  = 16'h000a;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int DCR_STEP_NS   = 10000;
    localparam int DCR_STEP_CYC  = DCR_STEP_NS / CLK_PERIOD_NS;
    localparam int DCR_MAX_SHIFT = 3;

endpackage

// *** pkg/cis_mon_if.sv ***
// supply monitor results passed to the supervisor core
`timescale 1ns/10ps
interface cis_mon_if;
    logic input_valid;
    logic ovp_lock;
    logic uvlo_lock;
    logic charge_ok;

    modport src (
        output input_valid,
        output ovp_lock,
        output uvlo_lock,
        output charge_ok
    );
    modport dst (
        input input_valid,
        input ovp_lock,
        input uvlo_lock,
        input charge_ok
    );
endinterface

// *** hw/cis_supply_monitor.sv ***
// over-voltage and under-voltage supervision of the charger input
`timescale 1ns/10ps
module cis_supply_monitor
    import cis_pkg::*;
(
    // clock, reset and enable
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // measured input and threshold select
    input  wire logic [MW-1:0] vin_mv_i,
    input  wire logic [1:0]    ovp_sel_i,
    // results
    cis_mon_if.src             mon
);

    logic [MW-1:0] ovp_th;
    logic [MW:0]   uvlo_release;
    logic          ovp_q;
    logic          uvlo_q;

    always_comb begin
        case (ovp_sel_i)
            2'h0:    ovp_th = OVP_TH_00;
            2'h1:    ovp_th = OVP_TH_01;
            2'h2:    ovp_th = OVP_TH_10;
            default: ovp_th = OVP_TH_11;
        endcase
    end

    assign uvlo_release = {1'b0, UVLO_TH} + {1'b0, UVLO_HYST};

    // ********************************************************
    // over-voltage lock
    // ********************************************************
    // resume below fixed limit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovp_q <= 1'b0;
        end else if (ce_i) begin
            if (vin_mv_i > ovp_th) begin
                ovp_q <= 1'b1;
            end else if (vin_mv_i < OVP_RESUME) begin
                ovp_q <= 1'b0;
            end
        end
    end

    // ********************************************************
    // under-voltage lock
    // ********************************************************
    // lockout with hysteresis
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uvlo_q <= 1'b1;
        end else if (ce_i) begin
            if (vin_mv_i < UVLO_TH) begin
                uvlo_q <= 1'b1;
            end else if ({1'b0, vin_mv_i} >= uvlo_release) begin
                uvlo_q <= 1'b0;
            end
        end
    end

    assign mon.input_valid = (vin_mv_i >= UVLO_TH) && (vin_mv_i <= ovp_th);
    assign mon.ovp_lock    = ovp_q;
    assign mon.uvlo_lock   = uvlo_q;
    assign mon.charge_ok   = !ovp_q && !uvlo_q;

endmodule

// *** hw/cis_current_select.sv ***
// input current limit and charge current selection
`timescale 1ns/10ps
module cis_current_select
    import cis_pkg::*;
(
    // mode pins
    input  wire logic          adapter_i,
    input  wire logic          level_i,
    // programmed fast charge current and droop reduction
    input  wire logic [MW-1:0] ichg_ma_i,
    input  wire logic [1:0]    shift_i,
    // selected currents
    output logic      [MW-1:0] ilim_ma_o,
    output logic      [MW-1:0] chg_ma_o,
    output logic      [MW-1:0] pre_ma_o
);

    logic [MW-1:0] chg_base;

    always_comb begin
        if (adapter_i) begin
            ilim_ma_o = ILIM_AC;
        end else if (level_i) begin
            ilim_ma_o = ILIM_USB_HI;
        end else begin
            ilim_ma_o = ILIM_USB_LO;
        end
    end

    // ac mode low level divides by five
    always_comb begin
        if (adapter_i) begin
            chg_base = level_i ? ichg_ma_i : ichg_ma_i / AC_LOW_DIV;
        end else begin
            chg_base = level_i ? CHG_USB_HI : CHG_USB_LO;
        end
    end

    assign chg_ma_o = chg_base >> shift_i;

    assign pre_ma_o = adapter_i ? (ichg_ma_i / PRE_AC_DIV) : PRE_USB;

endmodule

// *** hw/cis_supervisor.sv ***
// charger input supervisor: power path, protection, current select, events
//
// Behaviour
// - valid input powers system and charges; else battery; overload uses both
// - charging stops above two-bit selected 6.6/7.0/7.5/8.0V limit
// - after over-voltage, charging resumes only below 6.0V
// - usb mode limits 100mA or 450mA by level; ac mode about 2A
// - below 3.5V charger locks out; restarts 500mV above that
// - system rail sag over 200mV lowers charge current
// - ac mode with level low cuts fast-charge current by five
// - precondition 45mA in usb mode, ten percent of programmed in ac
// - connect raises interrupt when status and connect enable are set
// - disconnect raises interrupt when status and disconnect enable set
// - valid flag is one between under- and over-voltage thresholds
// - input event status reads one after event, cleared by read
// - adapter level flag readable anytime, follows adapter input
// - interrupt output low until status is read, written clear or masked
`timescale 1ns/10ps
module cis_supervisor
    import cis_pkg::*;
(
    // clock, reset and enable
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // converter words from the analog side, in mV and mA
    input  wire logic [MW-1:0] charger_supply_input_mv_i,
    input  wire logic [MW-1:0] system_rail_mv_i,
    input  wire logic [MW-1:0] system_load_ma_i,
    input  wire logic [MW-1:0] current_program_resistor_pin_ma_i,
    // mode pins
    input  wire logic          adapter_mode_input_i,
    input  wire logic          charge_level_select_i,
    // register port
    input  wire logic [AW-1:0] reg_addr_i,
    input  wire logic [DW-1:0] reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [DW-1:0] reg_rdata_o,
    // power path and charger control
    output logic               path_input_o,
    output logic               path_battery_o,
    output logic               charge_enable_o,
    output logic      [MW-1:0] input_limit_ma_o,
    output logic      [MW-1:0] charge_current_ma_o,
    output logic      [MW-1:0] precharge_current_ma_o,
    output logic               dynamic_current_reduction_o,
    // interrupt
    output logic               interrupt_out_n_o
);

    localparam int SYNC_W = 4 * MW + 2;
    localparam int STEP_W = $clog2(DCR_STEP_CYC + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(DCR_STEP_CYC - 1);
    localparam logic [1:0] SHIFT_MAX = 2'(DCR_MAX_SHIFT);

    if (DCR_STEP_CYC < 1) begin
        $error("droop step shorter than one clock");
    end

    // ********************************************************
    // input synchronisers
    // ********************************************************
    // converter words are assumed to change slowly against the clock
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] pins_raw;

    assign pins_raw = {charger_supply_input_mv_i, system_rail_mv_i,
                       system_load_ma_i, current_program_resistor_pin_ma_i,
                       adapter_mode_input_i, charge_level_select_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce_i) begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    logic [MW-1:0] vin_mv;
    logic [MW-1:0] system_rail_mv;
    logic [MW-1:0] load_ma;
    logic [MW-1:0] ichg_ma;
    logic          adapter;
    logic          level;

    assign {vin_mv, system_rail_mv, load_ma, ichg_ma, adapter, level} = sync2_q;

    // ********************************************************
    // register storage
    // ********************************************************
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [MW-1:0]     rail_ref_q;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic              wr_ref;
    logic              rd_stat;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CTRL);
    assign wr_stat = reg_wr_i && (reg_addr_i == OFF_IRQ_STAT);
    assign wr_mask = reg_wr_i && (reg_addr_i == OFF_IRQ_MASK);
    assign wr_ref  = reg_wr_i && (reg_addr_i == OFF_RAIL_REF);
    assign rd_stat = reg_rd_i && (reg_addr_i == OFF_IRQ_STAT);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q     <= CTRL_RST;
            irq_mask_q <= IRQ_MASK_RST;
            rail_ref_q <= RAIL_REF_RST;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i[CTRL_W-1:0];
            end
            if (wr_mask) begin
                irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
            end
            if (wr_ref) begin
                rail_ref_q <= reg_wdata_i[MW-1:0];
            end
        end
    end

    // ********************************************************
    // supply monitor and current selection
    // ********************************************************
    cis_mon_if mon ();

    cis_supply_monitor u_mon (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .vin_mv_i  (vin_mv),
        .ovp_sel_i (ctrl_q[CTRL_OVP_LSB +: 2]),
        .mon       (mon.src)
    );

    logic [1:0]    shift_q;
    logic [MW-1:0] ilim_ma;
    logic [MW-1:0] chg_ma;
    logic [MW-1:0] pre_ma;

    cis_current_select u_cur (
        .adapter_i (adapter),
        .level_i   (level),
        .ichg_ma_i (ichg_ma),
        .shift_i   (shift_q),
        .ilim_ma_o (ilim_ma),
        .chg_ma_o  (chg_ma),
        .pre_ma_o  (pre_ma)
    );

    // ********************************************************
    // dynamic charge current reduction
    // ********************************************************
    logic [STEP_W-1:0] step_q;
    logic              sag;

    assign sag = ({1'b0, system_rail_mv} + {1'b0, RAIL_DROOP}) < {1'b0, rail_ref_q};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_q <= '0;
        end else if (ce_i) begin
            step_q <= (step_q == STEP_LAST) ? '0 : step_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= 2'h0;
        end else if (ce_i && (step_q == STEP_LAST)) begin
            if (sag && (shift_q != SHIFT_MAX)) begin
                shift_q <= shift_q + 2'h1;
            end else if (!sag && (shift_q != 2'h0)) begin
                shift_q <= shift_q - 2'h1;
            end
        end
    end

    // ********************************************************
    // power path and charger outputs
    // ********************************************************
    logic overload;

    assign overload = load_ma > ilim_ma;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            path_input_o                <= 1'b0;
            path_battery_o              <= 1'b1;
            charge_enable_o             <= 1'b0;
            input_limit_ma_o            <= '0;
            charge_current_ma_o         <= '0;
            precharge_current_ma_o      <= '0;
            dynamic_current_reduction_o <= 1'b0;
        end else if (ce_i) begin
            path_input_o   <= mon.input_valid;
            path_battery_o <= !mon.input_valid || overload;
            charge_enable_o             <= mon.input_valid && mon.charge_ok;
            input_limit_ma_o            <= ilim_ma;
            charge_current_ma_o         <= chg_ma;
            precharge_current_ma_o      <= pre_ma;
            dynamic_current_reduction_o <= shift_q != 2'h0;
        end
    end

    // ********************************************************
    // connect and disconnect events
    // ********************************************************
    logic valid_q;
    logic ev_con;
    logic ev_dis;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
        end else if (ce_i) begin
            valid_q <= mon.input_valid;
        end
    end

    assign ev_con = mon.input_valid && !valid_q && ctrl_q[CTRL_CON_EN];
    assign ev_dis = !mon.input_valid && valid_q && ctrl_q[CTRL_DIS_EN];

    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign irq_set = {ev_con || ev_dis, ev_dis, ev_con};

    always_comb begin
        irq_clr = wr_stat ? reg_wdata_i[IRQ_W-1:0] : '0;
        if (rd_stat) begin
            irq_clr = '1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_q <= IRQ_STAT_RST;
        end else if (ce_i) begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    assign interrupt_out_n_o = !(|(irq_stat_q & irq_mask_q));

    // ********************************************************
    // register read port
    // ********************************************************
    logic [DW-1:0] status_word;
    logic [DW-1:0] rd_mux;

    always_comb begin
        status_word              = '0;
        status_word[ST_VALID]    = mon.input_valid;
        status_word[ST_ADAPTER]  = adapter;
        status_word[ST_CHG_EN]   = charge_enable_o;
        status_word[ST_OVP]      = mon.ovp_lock;
        status_word[ST_UVLO]     = mon.uvlo_lock;
        status_word[ST_DCR]      = dynamic_current_reduction_o;
        status_word[ST_PATH_IN]  = path_input_o;
        status_word[ST_PATH_BT]  = path_battery_o;
        status_word[ST_SHIFT +: 2] = shift_q;
    end

    always_comb begin
        case (reg_addr_i)
            OFF_CTRL:     rd_mux = {{(DW-CTRL_W){1'b0}}, ctrl_q};
            OFF_IRQ_STAT: rd_mux = {{(DW-IRQ_W){1'b0}}, irq_stat_q};
            OFF_IRQ_MASK: rd_mux = {{(DW-IRQ_W){1'b0}}, irq_mask_q};
            OFF_STATUS:   rd_mux = status_word;
            OFF_ILIM:     rd_mux = {{(DW-MW){1'b0}}, input_limit_ma_o};
            OFF_CHG:      rd_mux = {precharge_current_ma_o, charge_current_ma_o};
            OFF_RAIL_REF: rd_mux = {{(DW-MW){1'b0}}, rail_ref_q};
            default:      rd_mux = '0;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
        end
    end

endmodule

// *** verification/cis_supervisor_assertions.sv ***
// concurrent checks on the supervisor top-level ports
`timescale 1ns/10ps
module cis_supervisor_assertions
    import cis_pkg::*;
(
    // clock and reset
    input wire logic          clk_i,
    input wire logic          rst_i,
    // analog and pin side
    input wire logic [MW-1:0] charger_supply_input_mv_i,
    input wire logic [MW-1:0] current_program_resistor_pin_ma_i,
    input wire logic          adapter_mode_input_i,
    input wire logic          charge_level_select_i,
    // register port
    input wire logic [AW-1:0] reg_addr_i,
    input wire logic          reg_wr_i,
    input wire logic          reg_rd_i,
    input wire logic [DW-1:0] reg_rdata_o,
    // outputs
    input wire logic          path_input_o,
    input wire logic          path_battery_o,
    input wire logic          charge_enable_o,
    input wire logic [MW-1:0] input_limit_ma_o,
    input wire logic [MW-1:0] charge_current_ma_o,
    input wire logic [MW-1:0] precharge_current_ma_o,
    input wire logic          dynamic_current_reduction_o,
    input wire logic          interrupt_out_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_PATH_FED: assert property (path_input_o || path_battery_o)
        else $error("system rail left unfed");
    AST_CHG_PATH: assert property (charge_enable_o |-> path_input_o)
        else $error("charging without input path");
    AST_OVP_OFF: assert property ((charger_supply_input_mv_i > OVP_TH_11)[*5] |-> !charge_enable_o)
        else $error("charging above over-voltage limit");
    AST_UVLO_OFF: assert property ((charger_supply_input_mv_i < UVLO_TH)[*5] |-> !charge_enable_o)
        else $error("charging below lockout level");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read slot");
    AST_IRQ_RELEASE: assert property ($rose(interrupt_out_n_o) |->
        $past(reg_wr_i) || $past(reg_rd_i && reg_addr_i == OFF_IRQ_STAT))
        else $error("interrupt released without host access");
    AST_ILIM_USB: assert property ((!adapter_mode_input_i && !charge_level_select_i)[*6]
        ##0 path_input_o |-> input_limit_ma_o == ILIM_USB_LO)
        else $error("usb low input limit wrong");
    AST_PRE_USB: assert property ((!adapter_mode_input_i)[*6] ##0 charge_enable_o
        |-> precharge_current_ma_o == PRE_USB)
        else $error("usb precondition current wrong");
    AST_AC_DIV: assert property ((adapter_mode_input_i && !charge_level_select_i
        && $stable(current_program_resistor_pin_ma_i) && !dynamic_current_reduction_o)[*6]
        ##0 charge_enable_o |-> charge_current_ma_o ==
        current_program_resistor_pin_ma_i / AC_LOW_DIV)
        else $error("ac low charge current wrong");

    COV_IRQ: cover property (!interrupt_out_n_o);
    COV_BOTH: cover property (path_input_o && path_battery_o);
    COV_DCR: cover property (dynamic_current_reduction_o);
endmodule
bind cis_supervisor cis_supervisor_assertions u_chk (.*);

// *** verification/cis_supply_model.sv ***
// input supply adapter model driving the analog and pin side
`timescale 1ns/10ps
module cis_supply_model
    import cis_pkg::*;
(
    // clock
    input  wire logic          clk_i,
    // supply levels and pins
    output logic      [MW-1:0] vin_mv_o,
    output logic      [MW-1:0] rail_mv_o,
    output logic      [MW-1:0] load_ma_o,
    output logic      [MW-1:0] ichg_ma_o,
    output logic               adapter_o,
    output logic               level_o
);
    initial begin
        vin_mv_o = 16'h0000;
        rail_mv_o = 16'h1388;
        load_ma_o = 16'h0000;
        ichg_ma_o = 16'h03e8;
        adapter_o = 1'b0;
        level_o = 1'b0;
    end

    task automatic apply(input logic [MW-1:0] v, r, l, i, input logic a, c);
        @(posedge clk_i);
        vin_mv_o <= v;
        rail_mv_o <= r;
        load_ma_o <= l;
        ichg_ma_o <= i;
        adapter_o <= a;
        level_o <= c;
    endtask
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the charger input supervisor
`timescale 1ns/10ps
module tb_top
    import cis_pkg::*;
;
    logic          clk_i;
    logic          rst_i;
    logic [MW-1:0] vin, rail, load, ichg;
    logic          ada, lev;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata, d;
    logic          wr, rd_s, ce;
    logic          p_in, p_bt, chg_en, dcr, irq_n;
    logic [MW-1:0] ilim, chg, pre;
    int            err_total;
    int            compares;

    cis_supply_model sup (.clk_i(clk_i), .vin_mv_o(vin), .rail_mv_o(rail),
        .load_ma_o(load), .ichg_ma_o(ichg), .adapter_o(ada), .level_o(lev));
    cis_supervisor dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .charger_supply_input_mv_i(vin), .system_rail_mv_i(rail),
        .system_load_ma_i(load), .current_program_resistor_pin_ma_i(ichg),
        .adapter_mode_input_i(ada), .charge_level_select_i(lev),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .path_input_o(p_in), .path_battery_o(p_bt),
        .charge_enable_o(chg_en), .input_limit_ma_o(ilim), .charge_current_ma_o(chg),
        .precharge_current_ma_o(pre), .dynamic_current_reduction_o(dcr),
        .interrupt_out_n_o(irq_n));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ********************************************************
    // register port and supply helpers
    // ********************************************************
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge clk_i);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic supply(input logic [MW-1:0] v, r, l, i, input logic a, c);
        sup.apply(v, r, l, i, a, c);
        repeat (6) @(posedge clk_i);
        #1;
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset();
        chk(irq_n, 1'b1);
        rd_reg(OFF_CTRL, d); chk(d, 32'h0);
        rd_reg(OFF_IRQ_MASK, d); chk(d, 32'h7);
        rd_reg(OFF_RAIL_REF, d); chk(d, 32'h1130);
        rd_reg(8'h1c, d); chk(d, 32'h0);
    endtask

    task automatic t_connect();
        wr_reg(OFF_CTRL, 32'hc);
        supply(16'h1388, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
        chk(irq_n, 1'b0);
        rd_reg(OFF_STATUS, d); chk(d, 32'h45);
        rd_reg(OFF_IRQ_STAT, d); chk(d, 32'h5);
        rd_reg(OFF_IRQ_STAT, d); chk(d, 32'h0);
        chk(irq_n, 1'b1);
        rd_reg(OFF_CHG, d); chk(d, {16'h002d, 16'h005a});
    endtask

    task automatic t_uvlo();
        wr_reg(OFF_CTRL, 32'h8);
        supply(UVLO_TH - 16'h1, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
        chk(chg_en, 1'b0);
        rd_reg(OFF_IRQ_STAT, d); chk(d, 32'h6);
        supply(UVLO_TH + UVLO_HYST - 16'h1, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
        chk(chg_en, 1'b0);
        supply(UVLO_TH + UVLO_HYST, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
        chk(chg_en, 1'b1);
        supply(UVLO_TH - 16'h1, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
        chk(irq_n, 1'b0);
        wr_reg(OFF_IRQ_MASK, 32'h0); chk(irq_n, 1'b1);
        wr_reg(OFF_IRQ_MASK, 32'h7); chk(irq_n, 1'b0);
        wr_reg(OFF_IRQ_STAT, 32'h7); chk(irq_n, 1'b1);
        @(posedge clk_i) ce <= 1'b0;
        wr_reg(OFF_IRQ_MASK, 32'h0);
        @(posedge clk_i) ce <= 1'b1;
        rd_reg(OFF_IRQ_MASK, d); chk(d, 32'h7);
    endtask

    task automatic t_ovp();
        logic [MW-1:0] thr [4];
        thr = '{OVP_TH_00, OVP_TH_01, OVP_TH_10, OVP_TH_11};
        for (int s = 0; s < 4; s++) begin
            wr_reg(OFF_CTRL, DW'(s));
            supply(thr[s] + 16'h1, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
            chk(chg_en, 1'b0);
            rd_reg(OFF_STATUS, d); chk(d & 32'h19, 32'h08);
            supply(thr[s], 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
            rd_reg(OFF_STATUS, d); chk(d & 32'h1d, 32'h09);
            supply(OVP_RESUME, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
            chk(chg_en, 1'b0);
            supply(OVP_RESUME - 16'h1, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b0);
            chk(chg_en, 1'b1);
        end
    endtask

    task automatic t_modes();
        logic [MW-1:0] el [4];
        logic [MW-1:0] ec [4];
        logic [MW-1:0] ep [4];
        el = '{16'h0064, 16'h01c2, 16'h07d0, 16'h07d0};
        ec = '{16'h005a, 16'h01c2, 16'h00c8, 16'h03e8};
        ep = '{16'h002d, 16'h002d, 16'h0064, 16'h0064};
        for (int i = 0; i < 4; i++) begin
            supply(16'h1388, 16'h1388, 16'h0, 16'h03e8, i[1], i[0]);
            chk(ilim, el[i]);
            chk(chg, ec[i]);
            chk(pre, ep[i]);
            chk({p_in, p_bt}, 2'b10);
            rd_reg(OFF_STATUS, d); chk(d[ST_ADAPTER], i[1]);
            rd_reg(OFF_ILIM, d); chk(d, el[i]);
        end
    endtask

    task automatic t_overload();
        supply(16'h1388, 16'h1388, 16'h0258, 16'h03e8, 1'b0, 1'b1);
        chk({p_in, p_bt}, 2'b11);
        supply(16'h0, 16'h1388, 16'h0, 16'h03e8, 1'b0, 1'b1);
        chk({p_in, p_bt}, 2'b01);
    endtask

    task automatic t_droop();
        supply(16'h1388, 16'h1004, 16'h0, 16'h03e8, 1'b1, 1'b1);
        repeat (1000) @(posedge clk_i);
        chk(dcr, 1'b1);
        chk(chg, 16'h007d);
        wr_reg(OFF_RAIL_REF, 32'hf00);
        rd_reg(OFF_RAIL_REF, d); chk(d, 32'hf00);
        repeat (1000) @(posedge clk_i);
        chk({dcr, chg}, {1'b0, 16'h03e8});
    endtask

    initial begin
        err_total = 0;
        compares = 0;
        rst_i = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd_s = 1'b0;
        ce = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_connect();
        t_uvlo();
        t_ovp();
        t_modes();
        t_overload();
        t_droop();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        close_out();
    end
endmodule
